// file: verilog/mc_link_params.svh
`ifndef MC_LINK_PARAMS_SVH
`define MC_LINK_PARAMS_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFF_CTRL 8'h00
`define OFF_PORT 8'h04
`define OFF_LOOP 8'h08
`define OFF_SLOT 8'h0c
`define OFF_CMD 8'h10
`define OFF_STATUS 8'h14
`define OFF_LOGCNT 8'h18
`define OFF_LOGPTR 8'h1c
`define OFF_LOGDATA 8'h20
`define OFF_LOGPUSH 8'h24
// ************************************************************
// control field positions
// ************************************************************
`define CTRL_ANEG 0
`define CTRL_PASS 1
`define CTRL_FAULT 2
`define CTRL_JUMBO 3
`define CTRL_SRC_SW 4
`define CTRL_SW_VALID 5
`define CTRL_RST 8'h2e
`define PORT_RST 8'h03
`define LOOP_RST 8'h00
`define SLOT_RST 8'h03
`define CMD_RESTART 0
`define CMD_FACTORY 1
// ************************************************************
// timing
// ************************************************************
`define SPEED_1000 2'h2
`define RESTART_NS 1000
`define CLK_NS 20
`define RESTART_CYC ((`RESTART_NS + `CLK_NS - 1) / `CLK_NS)
`define LOG_DEPTH 200
`endif

// file: verilog/mc_link_pkg.sv
package mc_link_pkg;
	// effective link settings after source selection
	typedef struct packed {
		logic aneg;
		logic pass;
		logic fault;
		logic jumbo;
	} link_cfg_t;
	// per-port status sampled from the transceiver
	typedef struct packed {
		logic link_up;
		logic los;
	} port_stat_t;
	// negotiation/forced mode, one setting shared by both fiber ports
	typedef struct packed {
		logic aneg_en;
		logic [1:0] speed;
		logic full_dup;
		logic half_dup;
		logic pause;
	} port_mode_t;
	typedef enum logic [1:0] {RUN, RESTART} ctl_state_t;
endpackage

// file: verilog/alert_log.sv
`timescale 1ns/100ps
`default_nettype none
`include "mc_link_params.svh"
module alert_log #(
	parameter int DEPTH = `LOG_DEPTH,
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic [W-1:0] data_i,
	input wire logic [7:0] rd_idx_i,
	output logic [W-1:0] rd_data_o,
	output logic [7:0] count_o,
	output logic [7:0] wr_ptr_o
);
	logic [W-1:0] mem [DEPTH];
	logic [7:0] wr_q;
	logic [7:0] cnt_q;
	logic [7:0] nxt;
	// circular pointer; newest overwrites oldest once full
	assign nxt = (wr_q == 8'(DEPTH - 1)) ? 8'h00 : wr_q + 8'h01; // R6
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= 8'h00;
			cnt_q <= 8'h00;
		end
		else if (push_i)
		begin
			wr_q <= nxt; // R6
			if (cnt_q != 8'(DEPTH))
				cnt_q <= cnt_q + 8'h01;
		end
	end
	// storage has no reset; count tells software what is valid
	always_ff @(posedge clk_i)
	begin
		if (push_i)
			mem[wr_q] <= data_i;
		rd_data_o <= (rd_idx_i < 8'(DEPTH)) ? mem[rd_idx_i] : '0;
	end
	assign count_o = cnt_q;
	assign wr_ptr_o = wr_q;
endmodule
`default_nettype wire

// file: verilog/fiber_port_path.sv
`timescale 1ns/100ps
`default_nettype none
`include "mc_link_params.svh"
module fiber_port_path #(
	parameter int DW = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic loop_i,
	input wire logic tx_off_i,
	input wire logic fef_i,
	input wire logic [DW-1:0] rx_data_i,
	input wire logic [DW-1:0] fwd_data_i,
	output logic [DW-1:0] tx_data_o,
	output logic [DW-1:0] out_data_o,
	output logic tx_dis_o,
	output logic fef_o
);
	logic [DW-1:0] tx_sel;
	// loopback returns rx to own tx, else the other side's data
	assign tx_sel = loop_i ? rx_data_i : fwd_data_i; // R4
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_data_o <= '0;
			out_data_o <= '0;
			tx_dis_o <= 1'b1;
			fef_o <= 1'b0;
		end
		else
		begin
			tx_data_o <= en_i ? tx_sel : '0; // R18
			out_data_o <= (en_i && !loop_i) ? rx_data_i : '0; // R3
			tx_dis_o <= !en_i || tx_off_i; // R13
			fef_o <= en_i && fef_i; // R9
		end
	end
endmodule
`default_nettype wire

// file: verilog/mc_link_ctrl.sv
// Summary of operation
// R1: auto-neg advertises 1000 full/half, no pause
// R2: auto-neg off forces 1000 full duplex
// R3: loopback off forwards fiber receive data
// R4: loopback on returns rx to tx
// R5: one loopback port at most, default off
// R6: alert log keeps newest 200, circular
// R7: pass-through mirrors links between both fibers
// R8: standard mode keeps fiber links independent
// R9: loss of signal sends far-end fault indication
// R10: far-end fault only with auto-neg off
// R11: smart pass-through mirrors fiber and copper links
// R12: standard mode keeps fiber and copper independent
// R13: loss of signal disables fiber transmitter
// R14: fault alert only with negotiation off
// R15: one negotiation setting for both fibers
// R16: config source auto or switches
// R17: jumbo enable, default on
// R18: independent per-port enables
// R19: slot power command, default on
// R20: management restores config on insertion
// R21: restart or factory default on command
// R22: status sampled, actions within two cycles
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "mc_link_params.svh"
module mc_link_ctrl #(
	parameter int DW = 10,
	parameter int LOG_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// hardware switches: bit0 aneg, 1 pass, 2 fault, 3 jumbo
	input wire logic [3:0] dip_i,
	// fiber ports
	input wire logic [1:0] fib_link_i,
	input wire logic [1:0] fib_los_i,
	input wire logic [DW-1:0] fib0_rx_i,
	input wire logic [DW-1:0] fib1_rx_i,
	output logic [DW-1:0] fib0_tx_o,
	output logic [DW-1:0] fib1_tx_o,
	output logic [1:0] fib_tx_dis_o,
	output logic [1:0] far_end_fault_indication_o,
	output logic [1:0] fib_force_down_o,
	output mc_link_pkg::port_mode_t fib_mode_o,
	// copper side
	input wire logic cu_link_i,
	input wire logic [DW-1:0] cu_rx_i,
	output logic [DW-1:0] cu_tx_o,
	output logic cu_force_down_o,
	// misc
	output logic jumbo_en_o,
	output logic slot_pwr_o,
	output logic restart_o
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] ctrl_q;
	logic [1:0] port_en_q;
	logic [1:0] loop_q;
	logic [1:0] slot_q;
	logic [7:0] log_idx_q;
	logic ack_q;
	logic [31:0] rdat_q;
	mc_link_pkg::ctl_state_t st_q;
	logic [7:0] rcnt_q;
	logic factory_d;
	mc_link_pkg::port_stat_t [1:0] stat_q;
	logic cu_link_q;
	mc_link_pkg::link_cfg_t cfg;
	logic req;
	logic wr;
	logic [1:0] loop_d;
	logic [31:0] rd_mux;
	logic [LOG_W-1:0] log_rdata;
	logic [7:0] log_cnt;
	logic [7:0] log_ptr;
	logic log_push;
	logic [LOG_W-1:0] log_data;
	logic [1:0] los_prev_q;
	logic sw_push;
	logic [1:0] los_act;
	logic [1:0] mon;
	logic [DW-1:0] fwd0;
	logic [DW-1:0] fwd1;
	logic [DW-1:0] out0;
	logic [DW-1:0] out1;

	// function: write byte lane 0 with select
	function automatic logic [7:0] wb_byte(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s);
		wb_byte = s[0] ? d[7:0] : old;
	endfunction

	// ************************************************************
	// bus decode
	// ************************************************************
	// a write lands at the edge that raises ack; ack high blocks a repeat
	assign req = cyc_i && stb_i && !ack_q;
	assign wr = req && we_i;
	// a two-port request keeps only port 0, so at most one loops
	assign loop_d = (dat_i[1:0] == 2'h3) ? 2'h1 : dat_i[1:0]; // R5
	assign sw_push = wr && adr_i == `OFF_LOGPUSH && sel_i[0];
	assign factory_d = wr && adr_i == `OFF_CMD && sel_i[0] && dat_i[`CMD_FACTORY];

	// config source: software if selected and present, else switches
	assign cfg = (ctrl_q[`CTRL_SRC_SW] && ctrl_q[`CTRL_SW_VALID]) ?
		{ctrl_q[`CTRL_ANEG], ctrl_q[`CTRL_PASS], ctrl_q[`CTRL_FAULT], ctrl_q[`CTRL_JUMBO]} :
		{dip_i[0], dip_i[1], dip_i[2], dip_i[3]}; // R16

	// read mux; unmapped offsets read zero
	always_comb
	begin
		case (adr_i)
			`OFF_CTRL: rd_mux = {24'h0, ctrl_q};
			`OFF_PORT: rd_mux = {30'h0, port_en_q};
			`OFF_LOOP: rd_mux = {30'h0, loop_q};
			`OFF_SLOT: rd_mux = {30'h0, slot_q};
			`OFF_STATUS: rd_mux = {22'h0, cfg, cu_link_q, los_prev_q, stat_q[1].link_up,
				stat_q[0].link_up, (st_q == mc_link_pkg::RESTART)};
			`OFF_LOGCNT: rd_mux = {24'h0, log_cnt};
			`OFF_LOGPTR: rd_mux = {16'h0, log_ptr, log_idx_q};
			`OFF_LOGDATA: rd_mux = {{(32 - LOG_W){1'b0}}, log_rdata};
			default: rd_mux = 32'h0;
		endcase
	end

	// one wait state: ack in the cycle after the request is seen
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q <= req;
			rdat_q <= rd_mux;
		end
	end
	assign ack_o = ack_q;
	assign dat_o = rdat_q;

	// ************************************************************
	// configuration registers
	// ************************************************************
	// factory restore reloads every control to its default
	always_ff @(posedge clk_i)
	begin
		if (rst_i || factory_d) // R21
		begin
			ctrl_q <= `CTRL_RST; // R17
			port_en_q <= 2'(`PORT_RST);
			loop_q <= 2'(`LOOP_RST); // R5
			slot_q <= 2'(`SLOT_RST); // R19
			log_idx_q <= 8'h00;
		end
		else if (wr && sel_i[0])
		begin
			case (adr_i)
				`OFF_CTRL: ctrl_q <= wb_byte(ctrl_q, dat_i, sel_i);
				`OFF_PORT: port_en_q <= dat_i[1:0]; // R18
				`OFF_LOOP: loop_q <= loop_d; // R5
				`OFF_SLOT: slot_q <= dat_i[1:0]; // R19
				`OFF_LOGPTR: log_idx_q <= dat_i[7:0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// restart sequencer holds restart_o for a fixed time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q <= mc_link_pkg::RUN;
			rcnt_q <= 8'h00;
		end
		else
		begin
			case (st_q)
				mc_link_pkg::RUN:
					if (wr && adr_i == `OFF_CMD && sel_i[0] && dat_i[`CMD_RESTART]) // R21
					begin
						st_q <= mc_link_pkg::RESTART;
						rcnt_q <= 8'(`RESTART_CYC);
					end
				// the last count ends the pulse, so it lasts RESTART_CYC cycles
				mc_link_pkg::RESTART:
					if (rcnt_q == 8'h01)
						st_q <= mc_link_pkg::RUN;
					else
						rcnt_q <= rcnt_q - 8'h01;
				default: st_q <= mc_link_pkg::RUN;
			endcase
		end
	end

	// ************************************************************
	// link status and actions
	// ************************************************************
	// inputs sampled once; actions land one cycle later
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q <= '0;
			cu_link_q <= 1'b0;
			los_prev_q <= 2'h0;
		end
		else
		begin
			stat_q[0] <= {fib_link_i[0], fib_los_i[0]}; // R22
			stat_q[1] <= {fib_link_i[1], fib_los_i[1]}; // R22
			cu_link_q <= cu_link_i;
			los_prev_q <= {stat_q[1].los, stat_q[0].los};
		end
	end

	// fault monitoring only when negotiation off and feature on
	assign mon = {2{cfg.fault && !cfg.aneg}}; // R10 R14
	assign los_act = mon & {stat_q[1].los, stat_q[0].los}; // R9 R13

	// pass-through: a lost fiber link forces the other two down; a lost copper link forces only fiber 0
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fib_force_down_o <= 2'h0;
			cu_force_down_o <= 1'b0;
		end
		else if (cfg.pass) // R7 R11
		begin
			// copper is fiber 0's partner, so its loss drops fiber 0 too
			fib_force_down_o[0] <= !stat_q[1].link_up || !cu_link_q;
			fib_force_down_o[1] <= !stat_q[0].link_up;
			cu_force_down_o <= !(stat_q[0].link_up && stat_q[1].link_up);
		end
		else
		begin
			fib_force_down_o <= 2'h0; // R8 R12
			cu_force_down_o <= 1'b0;
		end
	end

	// advertised or forced mode, shared by both fibers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// forced gigabit until the first config is applied
			fib_mode_o.aneg_en <= 1'b0;
			fib_mode_o.speed <= `SPEED_1000;
			fib_mode_o.full_dup <= 1'b1;
			fib_mode_o.half_dup <= 1'b0;
			fib_mode_o.pause <= 1'b0;
		end
		else
		begin
			fib_mode_o.aneg_en <= cfg.aneg; // R15
			fib_mode_o.speed <= `SPEED_1000; // R1 R2
			fib_mode_o.full_dup <= 1'b1;
			fib_mode_o.half_dup <= cfg.aneg; // R1 R2
			fib_mode_o.pause <= 1'b0; // R1
		end
	end

	assign jumbo_en_o = cfg.jumbo; // R17
	assign slot_pwr_o = slot_q[0]; // R19
	assign restart_o = (st_q == mc_link_pkg::RESTART);

	// ************************************************************
	// datapath: fiber 0 pairs with copper, fiber 1 with fiber 0
	// ************************************************************
	assign fwd0 = cu_rx_i;
	assign fwd1 = out0;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cu_tx_o <= '0;
		else
			cu_tx_o <= out0 | out1; // R3
	end

	fiber_port_path #(.DW(DW)) u_p0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(port_en_q[0]),
		.loop_i(loop_q[0]),
		.tx_off_i(los_act[0]),
		.fef_i(los_act[0]),
		.rx_data_i(fib0_rx_i),
		.fwd_data_i(fwd0),
		.tx_data_o(fib0_tx_o),
		.out_data_o(out0),
		.tx_dis_o(fib_tx_dis_o[0]),
		.fef_o(far_end_fault_indication_o[0])
	);
	fiber_port_path #(.DW(DW)) u_p1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(port_en_q[1]),
		.loop_i(loop_q[1]),
		.tx_off_i(los_act[1]),
		.fef_i(los_act[1]),
		.rx_data_i(fib1_rx_i),
		.fwd_data_i(fwd1),
		.tx_data_o(fib1_tx_o),
		.out_data_o(out1),
		.tx_dis_o(fib_tx_dis_o[1]),
		.fef_o(far_end_fault_indication_o[1])
	);

	// ************************************************************
	// alert log: hardware loss-of-signal edges and software entries
	// ************************************************************
	assign log_push = sw_push || (|({stat_q[1].los, stat_q[0].los} & ~los_prev_q));
	assign log_data = sw_push ? dat_i[LOG_W-1:0] :
		{{(LOG_W - 2){1'b0}}, {stat_q[1].los, stat_q[0].los} & ~los_prev_q};

	alert_log #(.DEPTH(`LOG_DEPTH), .W(LOG_W)) u_log (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(log_push), // R6
		.data_i(log_data),
		.rd_idx_i(log_idx_q),
		.rd_data_o(log_rdata),
		.count_o(log_cnt),
		.wr_ptr_o(log_ptr)
	);
endmodule
`default_nettype wire

// file: bench/mc_link_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "mc_link_params.svh"
module mc_link_ctrl_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic [1:0] fib_link_i,
	input wire logic [1:0] fib_los_i,
	input wire logic cu_link_i,
	input wire logic [1:0] fib_tx_dis_o,
	input wire logic [1:0] far_end_fault_indication_o,
	input wire logic [1:0] fib_force_down_o,
	input wire logic cu_force_down_o,
	input wire mc_link_pkg::port_mode_t fib_mode_o,
	input wire logic slot_pwr_o,
	input wire logic restart_o
);
	logic [7:0] pulse_q;
	logic [7:0] pulse_d;
	// ****************************************
	// restart pulse length
	// ****************************************
	// an assertion counter, since a repetition of 50 would unroll badly
	assign pulse_d = restart_o ? pulse_q + 8'h01 : 8'h00;
	always_ff @(posedge clk_i)
	begin
		pulse_q <= rst_i ? 8'h00 : pulse_d;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************
	// properties
	// ****************************************
	chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged next cycle");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_adv_gig: assert property (fib_mode_o.aneg_en |-> fib_mode_o[4:0] == 5'b10110)
		else $error("bad advertised abilities");
	chk_forced_gig: assert property (!fib_mode_o.aneg_en |-> fib_mode_o[4:0] == 5'b10100)
		else $error("bad forced mode");
	chk_fef_cause: assert property ((far_end_fault_indication_o & ~$past(fib_los_i, 2)) == 2'h0)
		else $error("fault indication without loss of signal");
	chk_fef_aneg: assert property (fib_mode_o.aneg_en && $past(fib_mode_o.aneg_en)
		&& $past(fib_mode_o.aneg_en, 2) |-> far_end_fault_indication_o == 2'h0)
		else $error("fault indication while negotiating");
	chk_fef_txoff: assert property ((far_end_fault_indication_o & ~fib_tx_dis_o) == 2'h0)
		else $error("transmitter on during fault");
	chk_all_up: assert property (!$past(rst_i, 3) && $past(fib_link_i, 2) == 2'h3
		&& $past(cu_link_i, 2) |-> fib_force_down_o == 2'h0 && !cu_force_down_o)
		else $error("link forced down while all links up");
	chk_slot_boot: assert property ($fell(rst_i) |-> slot_pwr_o)
		else $error("slot power off after reset");
	chk_restart_len: assert property ($fell(restart_o) |-> pulse_q == `RESTART_CYC)
		else $error("restart pulse length wrong");
	cover property (far_end_fault_indication_o[0]);
	cover property (fib_force_down_o[1]);
	cover property ($fell(restart_o));
endmodule
bind mc_link_ctrl mc_link_ctrl_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .fib_link_i,
	.fib_los_i, .cu_link_i, .fib_tx_dis_o, .far_end_fault_indication_o, .fib_force_down_o,
	.cu_force_down_o, .fib_mode_o, .slot_pwr_o, .restart_o);
`default_nettype wire

// file: bench/remote_conv.sv
`timescale 1ns/100ps
`default_nettype none
module remote_conv (
	input wire logic clk_i,
	input wire logic [1:0] los_req_i,
	input wire logic [1:0] down_req_i,
	output logic [1:0] link_o = 2'h3,
	output logic [1:0] los_o = 2'h0,
	output logic [9:0] rx0_o = 10'h000,
	output logic [9:0] rx1_o = 10'h3ff
);
	logic [9:0] seq_q = 10'h001;
	// ****************************************
	// far converter line model
	// ****************************************
	// data changes every cycle; a dark fiber toggles so no stale value survives
	always_ff @(posedge clk_i)
	begin
		seq_q <= seq_q + 10'h0d3;
		rx0_o <= los_req_i[0] ? ~rx0_o : seq_q;
		rx1_o <= los_req_i[1] ? ~rx1_o : ~seq_q;
		los_o <= los_req_i;
		link_o <= ~los_req_i & ~down_req_i;
	end
endmodule
`default_nettype wire

// file: bench/media_converter_link_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module media_converter_link_control_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0;
	logic [3:0] dip_i = 4'he;
	logic cu_link_i = 1'b1;
	logic [9:0] cu_rx_i = 10'h155;
	logic [1:0] los_req = 2'h0;
	logic [1:0] down_req = 2'h0;
	logic [31:0] dat_o, q;
	logic ack_o, cu_force_down_o, jumbo_en_o, slot_pwr_o, restart_o;
	logic [1:0] fib_link_i, fib_los_i, fib_tx_dis_o, far_end_fault_indication_o, fib_force_down_o;
	logic [9:0] fib0_rx_i, fib1_rx_i, fib0_tx_o, fib1_tx_o, cu_tx_o, v;
	mc_link_pkg::port_mode_t fib_mode_o;
	logic [31:0] rst_tab [4] = '{32'h2e, 32'h03, 32'h00, 32'h03};
	int err_count = 0;
	int n_checks = 0;
	always #10 clk_i = ~clk_i;
	mc_link_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.dip_i, .fib_link_i, .fib_los_i, .fib0_rx_i, .fib1_rx_i, .fib0_tx_o, .fib1_tx_o,
		.fib_tx_dis_o, .far_end_fault_indication_o, .fib_force_down_o, .fib_mode_o, .cu_link_i,
		.cu_rx_i, .cu_tx_o, .cu_force_down_o, .jumbo_en_o, .slot_pwr_o, .restart_o);
	remote_conv far_end (.clk_i, .los_req_i(los_req), .down_req_i(down_req), .link_o(fib_link_i),
		.los_o(fib_los_i), .rx0_o(fib0_rx_i), .rx1_o(fib1_rx_i));
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic cycle; outputs read right after an edge still hold the sampled value
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		t = 0;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && t < 50)
		begin
			@(posedge clk_i);
			t++;
		end
		chk(ack_o, 32'h1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic line(input logic [3:0] dip, input logic [1:0] los, input logic [1:0] down);
		dip_i <= dip;
		los_req <= los;
		down_req <= down;
		repeat (5) @(posedge clk_i);
	endtask
	task automatic end_of_test();
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(slot_pwr_o, 32'h1);
		chk(jumbo_en_o, 32'h1);
		for (int i = 0; i < 4; i++)
			rd({i[5:0], 2'b00}, rst_tab[i]);
		wr(8'h3c, 32'hff);
		rd(8'h3c, 32'h0);
		// a full log plus one, so the oldest entry is overwritten
		for (int i = 1; i <= 201; i++)
			wr(8'h24, 32'(i));
		rd(8'h18, 32'd200);
		rd(8'h1c, 32'h100);
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h1c, 32'(i));
			rd(8'h18, 32'd200);
			rd(8'h20, i == 0 ? 32'hc9 : 32'h02);
		end
		chk(fib_mode_o, 32'h14);
		line(4'he, 2'b01, 2'b00);
		chk(fib_tx_dis_o, 32'h1);
		chk(far_end_fault_indication_o, 32'h1);
		chk(fib_force_down_o[1], 32'h1);
		chk(cu_force_down_o, 32'h1);
		line(4'h0, 2'b01, 2'b01);
		chk(fib_tx_dis_o, 32'h0);
		chk(far_end_fault_indication_o, 32'h0);
		chk(fib_force_down_o, 32'h0);
		chk(cu_force_down_o, 32'h0);
		chk(jumbo_en_o, 32'h0);
		line(4'he, 2'b00, 2'b00);
		rd(8'h14, 32'h1e6);
		// software source with negotiation and fault on differs from the switches
		wr(8'h00, 32'h35);
		line(4'he, 2'b01, 2'b00);
		chk(jumbo_en_o, 32'h0);
		chk(fib_mode_o, 32'h36);
		chk(far_end_fault_indication_o, 32'h0);
		chk(fib_tx_dis_o, 32'h0);
		wr(8'h00, 32'h11);
		line(4'he, 2'b00, 2'b00);
		chk(jumbo_en_o, 32'h1);
		chk(fib_mode_o, 32'h14);
		cu_link_i <= 1'b0;
		line(4'he, 2'b00, 2'b00);
		chk(fib_force_down_o, 32'h1);
		cu_link_i <= 1'b1;
		wr(8'h04, 32'h2);
		line(4'he, 2'b00, 2'b00);
		chk(fib_tx_dis_o, 32'h1);
		rd(8'h04, 32'h2);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h3);
		rd(8'h08, 32'h1);
		for (int p = 1; p <= 2; p++)
		begin
			wr(8'h08, 32'(p));
			@(posedge clk_i);
			v = p == 1 ? fib0_rx_i : fib1_rx_i;
			@(posedge clk_i);
			chk(p == 1 ? fib0_tx_o : fib1_tx_o, v);
		end
		wr(8'h08, 32'h0);
		@(posedge clk_i);
		v = fib0_rx_i | fib1_rx_i;
		repeat (2) @(posedge clk_i);
		chk(cu_tx_o, v);
		wr(8'h0c, 32'h2);
		@(posedge clk_i);
		chk(slot_pwr_o, 32'h0);
		wr(8'h10, 32'h2);
		repeat (2) @(posedge clk_i);
		rd(8'h00, 32'h2e);
		rd(8'h0c, 32'h3);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(restart_o, 32'h1);
		repeat (60) @(posedge clk_i);
		chk(restart_o, 32'h0);
		// management download after insertion brings the stored setting back
		wr(8'h00, 32'h35);
		rd(8'h00, 32'h35);
		end_of_test();
	end
	// the scenarios need well under a thousand cycles; this limit is far beyond that
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
